// [hw/bcd_step.sv]
`timescale 1ns/1ns
`default_nettype none
module bcd_step (
    input  wire logic [7:0] value,
    input  wire logic [7:0] lowest,
    input  wire logic [7:0] highest,
    output logic      [7:0] next,
    output logic            wrap
);
    // One BCD count step with wrap to the lowest legal value
    always_comb begin
        wrap = (value >= highest);
        if (wrap) begin
            next = lowest;
        end else if (value[3:0] >= 4'h9) begin
            next = {value[7:4] + 4'h1, 4'h0};
        end else begin
            next = {value[7:4], value[3:0] + 4'h1};
        end
    end
endmodule
`default_nettype wire

// [hw/nv_byte_mem.sv]
`timescale 1ns/1ns
`default_nettype none
module nv_byte_mem
    import nv_clock_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  writeEn,
    input  wire logic [ADDR_WIDTH-1:0] writeAddr,
    input  wire logic [DATA_WIDTH-1:0] writeData,
    input  wire logic [ADDR_WIDTH-1:0] readAddr,
    output var  logic [DATA_WIDTH-1:0] readData
);
    // No reset: contents are nonvolatile and survive everything
    logic [DATA_WIDTH-1:0] store [MEM_DEPTH];

    always_ff @(posedge clk) begin
        if (writeEn) begin
            store[writeAddr] <= writeData;
        end
        readData <= store[readAddr];
    end
endmodule
`default_nettype wire

// [hw/nv_clock_pkg.sv]
package nv_clock_pkg;
    localparam int unsigned ADDR_WIDTH = 11;
    localparam int unsigned DATA_WIDTH = 8;
    localparam int unsigned MEM_DEPTH  = 2048;
    // Clock register locations
    localparam logic [10:0] OFFS_CONTROL = 11'h7f8;
    localparam logic [10:0] OFFS_SECONDS = 11'h7f9;
    localparam logic [10:0] OFFS_MINUTES = 11'h7fa;
    localparam logic [10:0] OFFS_HOURS   = 11'h7fb;
    localparam logic [10:0] OFFS_WEEKDAY = 11'h7fc;
    localparam logic [10:0] OFFS_DATE    = 11'h7fd;
    localparam logic [10:0] OFFS_MONTH   = 11'h7fe;
    localparam logic [10:0] OFFS_YEAR    = 11'h7ff;
    // Field positions
    localparam int unsigned BIT_WRITE_HOLD = 7;
    localparam int unsigned BIT_READ_HOLD  = 6;
    localparam int unsigned BIT_OSC_STOP   = 7;
    localparam int unsigned BIT_BATT_GOOD  = 7;
    localparam int unsigned BIT_FREQ_TEST  = 6;
    // Per-register masks of the BCD count bits; the rest are control flags, the battery flag or plain storage
    localparam logic [7:0] MASK_CONTROL = 8'h3f;
    localparam logic [7:0] MASK_SECONDS = 8'h7f;
    localparam logic [7:0] MASK_MINUTES = 8'h7f;
    localparam logic [7:0] MASK_HOURS   = 8'h3f;
    localparam logic [7:0] MASK_WEEKDAY = 8'h07;
    localparam logic [7:0] MASK_DATE    = 8'h3f;
    localparam logic [7:0] MASK_MONTH   = 8'h1f;
    localparam logic [7:0] MASK_YEAR    = 8'hff;
    // Reset values of the count
    localparam logic [7:0] RESET_DAY    = 8'h01;
    localparam logic [7:0] RESET_ZERO   = 8'h00;
    // Timing at 100 MHz
    localparam int unsigned CLK_PERIOD_NS      = 10;
    localparam int unsigned OUTPUT_HOLD_NS     = 5;
    localparam int unsigned OUTPUT_HOLD_CYC    =
        (OUTPUT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TICK_HZ            = 1024;
    localparam int unsigned TICK_CYC           = 100_000_000 / TICK_HZ;
    localparam int unsigned TICKS_PER_SECOND   = 1024;
    localparam int unsigned READ_REFRESH_MS    = 1000;
    localparam logic [1:0]  HOLD_CNT_ONE       = 2'h1;
    // Timekeeping sequencer
    typedef enum logic [1:0] {
        TK_RUN   = 2'b00,
        TK_HOLD  = 2'b01,
        TK_LOAD  = 2'b10
    } tk_state_type;
endpackage

// [hw/nv_clock_ram_access.sv]
`timescale 1ns/1ns
`default_nettype none
module nv_clock_ram_access
    import nv_clock_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [ADDR_WIDTH-1:0] addressPins,
    input  wire logic                  chipSelectN,
    input  wire logic                  outputEnableN,
    input  wire logic                  writeStrobeN,
    input  wire logic [DATA_WIDTH-1:0] dataIn,
    output logic      [DATA_WIDTH-1:0] dataOut,
    output logic                       dataOe,
    output logic                       dataValid,
    input  wire logic                  powerFail,
    input  wire logic                  backupActive,
    input  wire logic                  batteryHealthy,
    output logic                       backupEnabled
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic isClockReg(input logic [ADDR_WIDTH-1:0] a);
        return a[10:3] == OFFS_CONTROL[10:3];
    endfunction

    function automatic logic [7:0] countMask(input logic [2:0] idx);
        unique case (idx)
            3'h0: return MASK_CONTROL;
            3'h1: return MASK_SECONDS;
            3'h2: return MASK_MINUTES;
            3'h3: return MASK_HOURS;
            3'h4: return MASK_WEEKDAY;
            3'h5: return MASK_DATE;
            3'h6: return MASK_MONTH;
            3'h7: return MASK_YEAR;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Access decode
    logic readMode;
    logic writeMode;
    logic accessOk;
    assign accessOk  = !powerFail;
    assign readMode  = accessOk && !chipSelectN && !outputEnableN && writeStrobeN;
    assign writeMode = accessOk && !chipSelectN && !writeStrobeN;

    ////////////////////////////////////////////////////////////////////////////
    // Visible register bank, running counters, control bits
    logic [7:0] visible_q [8];
    logic [7:0] visible_d [8];
    logic [7:0] count_q   [8];
    logic [7:0] count_d   [8];
    logic [7:0] nextCount [8];
    logic [7:0] wrapCount;
    logic       writeHold;
    logic       readHold;
    logic       oscStop;
    logic       freqTest;
    assign writeHold = visible_q[0][BIT_WRITE_HOLD];
    assign readHold  = visible_q[0][BIT_READ_HOLD];
    assign oscStop   = visible_q[1][BIT_OSC_STOP];
    assign freqTest  = visible_q[4][BIT_FREQ_TEST];

    // Tick generator: oscillator halts under the stop bit
    logic [16:0] tickCnt_q, tickCnt_d;
    logic [9:0]  subSec_q, subSec_d;
    logic        tick;
    logic        secTick;
    logic        oscRun;
    assign oscRun  = !oscStop && (backupEnabled || !backupActive);
    assign tick    = oscRun && (tickCnt_q == 17'(TICK_CYC - 1));
    assign secTick = tick && (subSec_q == 10'(TICKS_PER_SECOND - 1));

    // Counter chain: seconds, minutes, hours, day/date, month, year, century
    logic [7:0] lowV [8];
    logic [7:0] highV [8];
    assign lowV  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    assign highV = '{8'h39, 8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_step
            bcd_step u_step (
                .value   (count_q[g] & countMask(3'(g))),
                .lowest  (lowV[g]),
                .highest (highV[g]),
                .next    (nextCount[g]),
                .wrap    (wrapCount[g])
            );
        end
    endgenerate

    logic leapYear;
    logic [7:0] monthEnd;
    always_comb begin
        leapYear = (count_q[7][4] ? (count_q[7][3:0] % 4'h4 == 4'h2)
                                  : (count_q[7][3:0] % 4'h4 == 4'h0));
        unique case (count_q[6][4:0])
            5'h02:                        monthEnd = leapYear ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11:   monthEnd = 8'h30;
            default:                      monthEnd = 8'h31;
        endcase
    end

    logic [7:0] memRdData;
    logic [7:0] regRdData;
    always_comb begin
        logic carry;
        carry = secTick;
        for (int i = 0; i < 8; i++) begin
            count_d[i]   = count_q[i];
            visible_d[i] = visible_q[i];
        end
        tickCnt_d = tick ? 17'h0 : (oscRun ? tickCnt_q + 17'h1 : tickCnt_q);
        subSec_d  = tick ? subSec_q + 10'h1 : subSec_q;
        // Seconds, minutes, hours
        for (int i = 1; i < 4; i++) begin
            if (carry) begin
                count_d[i] = (count_q[i] & ~countMask(3'(i))) | nextCount[i];
            end
            carry = carry && wrapCount[i];
        end
        if (carry) begin
            count_d[4] = (count_q[4] & ~MASK_WEEKDAY) | nextCount[4];
            count_d[5] = (count_q[5][5:0] >= monthEnd[5:0]) ? 8'h01 : nextCount[5];
            carry = count_q[5][5:0] >= monthEnd[5:0];
        end
        for (int i = 6; i < 8; i++) begin
            if (carry) begin
                count_d[i] = (count_q[i] & ~countMask(3'(i))) | nextCount[i];
            end
            carry = carry && wrapCount[i];
        end
        if (carry) begin
            count_d[0] = nextCount[0];
        end
        // Visible copy follows the counters unless a hold bit is set
        if (!writeHold && !readHold) begin
            for (int i = 0; i < 8; i++) begin
                visible_d[i] = (visible_q[i] & ~countMask(3'(i)))
                             | (count_d[i] & countMask(3'(i)));
            end
        end
        // Host write
        if (writeMode && isClockReg(addressPins)) begin
            visible_d[addressPins[2:0]] = dataIn;
        end
        // Falling write-hold loads the counters
        if (writeHold && !visible_d[0][BIT_WRITE_HOLD]) begin
            // Take the bytes as just written so a century stored with the clear is kept
            for (int i = 0; i < 8; i++) begin
                count_d[i] = visible_d[i];
            end
            subSec_d  = 10'h0;
            tickCnt_d = 17'h0;
        end
        visible_d[4][BIT_BATT_GOOD] = batteryHealthy;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                count_q[i]   <= (i >= 4 && i <= 6) ? RESET_DAY : RESET_ZERO;
                visible_q[i] <= (i >= 4 && i <= 6) ? RESET_DAY : RESET_ZERO;
            end
            visible_q[4][BIT_BATT_GOOD] <= batteryHealthy;
            tickCnt_q <= 17'h0;
            subSec_q  <= 10'h0;
        end else begin
            count_q   <= count_d;
            visible_q <= visible_d;
            tickCnt_q <= tickCnt_d;
            subSec_q  <= subSec_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory array and read path
    nv_byte_mem u_mem (
        .clk       (clk),
        .writeEn   (writeMode && !isClockReg(addressPins)),
        .writeAddr (addressPins),
        .writeData (dataIn),
        .readAddr  (addressPins),
        .readData  (memRdData)
    );

    logic [ADDR_WIDTH-1:0] lastAddr_q;
    logic                  clkRegSel_q;
    logic [2:0]            regIdx_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            lastAddr_q  <= '0;
            clkRegSel_q <= 1'b0;
            regIdx_q    <= 3'h0;
        end else begin
            lastAddr_q  <= addressPins;
            clkRegSel_q <= isClockReg(addressPins);
            regIdx_q    <= addressPins[2:0];
        end
    end

    // Frequency test overrides seconds LSB with the 512 Hz square wave
    always_comb begin
        regRdData = visible_q[regIdx_q];
        if (regIdx_q == OFFS_SECONDS[2:0] && freqTest && oscRun) begin
            regRdData[0] = subSec_q[0];
        end
    end

    logic addrStable;
    assign addrStable = (lastAddr_q == addressPins);

    // Data out registered; valid marks the two-cycle address access
    logic [7:0] dout_q, dout_d;
    logic       valid_q, valid_d;
    always_comb begin
        dout_d  = dout_q;
        valid_d = 1'b0;
        if (readMode && addrStable) begin
            dout_d  = clkRegSel_q ? regRdData : memRdData;
            valid_d = 1'b1;
        end else if (readMode) begin
            valid_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dout_q  <= 8'h00;
            valid_q <= 1'b0;
        end else begin
            dout_q  <= dout_d;
            valid_q <= valid_d;
        end
    end

    assign dataOut   = dout_q;
    assign dataOe    = readMode;
    assign dataValid = valid_q && readMode;

    ////////////////////////////////////////////////////////////////////////////
    // Battery connect latch: set on first good power, never cleared by reset
    logic backup_q = 1'b0;
    logic backup_d;
    assign backup_d = backup_q || !powerFail;
    always_ff @(posedge clk) begin
        backup_q <= backup_d;
    end
    assign backupEnabled = backup_q;

    ////////////////////////////////////////////////////////////////////////////
    property p_pf_blocks;
        @(posedge clk) disable iff (rst) powerFail |-> !dataOe;
    endproperty
    a_pf_blocks: assert property (p_pf_blocks) else $error("Driven in power fail");

    property p_oe_gate;
        @(posedge clk) disable iff (rst) dataOe |-> (!chipSelectN && !outputEnableN);
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("Driven while deselected");

    property p_strobe_off;
        @(posedge clk) disable iff (rst) !writeStrobeN |-> !dataOe;
    endproperty
    a_strobe_off: assert property (p_strobe_off) else $error("Driven in write");

    sequence s_steady_read;
        readMode && addrStable && !clkRegSel_q;
    endsequence
    property p_ripple;
        @(posedge clk) disable iff (rst) s_steady_read ##1 readMode |-> dataValid && dataOut == $past(memRdData);
    endproperty
    a_ripple: assert property (p_ripple) else $error("Read data wrong");

    property p_read_mode;
        @(posedge clk) disable iff (rst) (!powerFail && !chipSelectN && !outputEnableN && writeStrobeN) |-> dataOe;
    endproperty
    a_read_mode: assert property (p_read_mode) else $error("Read not driven");

    property p_batt_flag;
        @(posedge clk) disable iff (rst) ##1 visible_q[4][BIT_BATT_GOOD] == $past(batteryHealthy);
    endproperty
    a_batt_flag: assert property (p_batt_flag) else $error("Battery flag wrong");

    property p_osc_stop;
        @(posedge clk) disable iff (rst) oscStop |-> !tick;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("Tick while stopped");

    property p_read_hold;
        @(posedge clk) disable iff (rst) (readHold && !writeMode) ##1 readHold |-> visible_q[2] == $past(visible_q[2]);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("Held register moved");

    property p_backup;
        @(posedge clk) !powerFail |=> backupEnabled [*2];
    endproperty
    a_backup: assert property (p_backup) else $error("Backup not enabled");
endmodule
`default_nettype wire

// [verif/host_bus_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
    import nv_clock_pkg::*;
(
    input  wire logic                  clk,
    output logic      [ADDR_WIDTH-1:0] addressPins,
    output logic                       chipSelectN,
    output logic                       outputEnableN,
    output logic                       writeStrobeN,
    output logic      [DATA_WIDTH-1:0] dataIn,
    input  wire logic [DATA_WIDTH-1:0] dataOut,
    input  wire logic                  dataOe,
    input  wire logic                  dataValid
);
    initial begin
        addressPins   = 11'h000;
        chipSelectN   = 1'b1;
        outputEnableN = 1'b1;
        writeStrobeN  = 1'b1;
        dataIn        = 8'h00;
    end
    ////////////////////////////////////////////////////////////
    // Address and data stay put from strobe edge through release
    task automatic write_byte(input logic [ADDR_WIDTH-1:0] addr, input logic [DATA_WIDTH-1:0] data,
                              input logic oeLow, output logic oeSeen);
        @(posedge clk);
        addressPins   <= addr;
        dataIn        <= data;
        chipSelectN   <= 1'b0;
        writeStrobeN  <= 1'b0;
        outputEnableN <= ~oeLow; // Low only where a scenario probes the turn-off
        @(posedge clk);
        oeSeen = dataOe;
        @(posedge clk);
        chipSelectN   <= 1'b1;
        writeStrobeN  <= 1'b1;
        outputEnableN <= 1'b1;
        // Released data line shows the inverse so a stale byte cannot pass
        dataIn        <= ~data;
        @(posedge clk); // Idle recovery cycle before the next access
    endtask
    ////////////////////////////////////////////////////////////
    task automatic read_byte(input logic [ADDR_WIDTH-1:0] addr, input logic rel,
                             output logic [DATA_WIDTH-1:0] data, output logic oeAny,
                             output logic validEarly, output logic ok);
        int i;
        logic moved;
        ok    = 1'b0;
        moved = (addressPins !== addr);
        oeAny = 1'b0;
        data  = 8'h00;
        @(posedge clk);
        addressPins   <= addr;
        chipSelectN   <= 1'b0;
        outputEnableN <= 1'b0;
        writeStrobeN  <= 1'b1;
        @(posedge clk);
        #1;
        // An unchanged address may legitimately be valid at once
        validEarly = moved && (dataValid === 1'b1);
        // Skipping the first edge keeps a stale valid from the old address out
        for (i = 0; i < 8 && ok == 1'b0; i++) begin
            @(posedge clk);
            oeAny = oeAny | (dataOe === 1'b1);
            if (dataValid === 1'b1) begin
                ok   = 1'b1;
                data = dataOut;
            end
        end
        if (rel) begin
            chipSelectN   <= 1'b1;
            outputEnableN <= 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb
    import nv_clock_pkg::*;
;
    logic                  clk;
    logic                  rst;
    logic [ADDR_WIDTH-1:0] addressPins;
    logic                  chipSelectN;
    logic                  outputEnableN;
    logic                  writeStrobeN;
    logic [DATA_WIDTH-1:0] dataIn;
    logic [DATA_WIDTH-1:0] dataOut;
    logic                  dataOe;
    logic                  dataValid;
    logic                  powerFail;
    logic                  backupActive;
    logic                  batteryHealthy;
    logic                  backupEnabled;
    int                    n_mismatch;
    int                    n_compared;
    logic [ADDR_WIDTH-1:0] ramAddr [3]  = '{11'h000, 11'h3a5, 11'h7f7};
    logic [DATA_WIDTH-1:0] ramData [3]  = '{8'ha5, 8'h5a, 8'hff};
    logic [DATA_WIDTH-1:0] resetVal [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h01, 8'h01, 8'h00};
    logic [DATA_WIDTH-1:0] setVal [8]   = '{8'h80, 8'hd9, 8'hd9, 8'he3, 8'h3f, 8'hf1, 8'hf2, 8'h99};
    logic [DATA_WIDTH-1:0] readVal [8]  = '{8'h39, 8'hd9, 8'hd9, 8'he3, 8'hbf, 8'hf1, 8'hf2, 8'h99};

    nv_clock_ram_access nv_clock_ram_access_inst (.clk(clk), .rst(rst), .addressPins(addressPins),
        .chipSelectN(chipSelectN), .outputEnableN(outputEnableN), .writeStrobeN(writeStrobeN),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .dataValid(dataValid),
        .powerFail(powerFail), .backupActive(backupActive), .batteryHealthy(batteryHealthy),
        .backupEnabled(backupEnabled));
    host_bus_model host_bus_model_inst (.clk(clk), .addressPins(addressPins), .chipSelectN(chipSelectN),
        .outputEnableN(outputEnableN), .writeStrobeN(writeStrobeN), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .dataValid(dataValid));

    initial clk = 1'b0;
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] d, input logic oeLow);
        logic oe;
        host_bus_model_inst.write_byte(a, d, oeLow, oe);
        check("dataOeWrite", {7'h00, oe}, 8'h00);
    endtask

    // A refused read is expected to time out; any other timeout ends the run
    task automatic rd(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] e, input logic rel,
                      input logic expOk);
        logic [DATA_WIDTH-1:0] d;
        logic                  oe;
        logic                  early;
        logic                  ok;
        host_bus_model_inst.read_byte(a, rel, d, oe, early, ok);
        check("dataValidEarly", {7'h00, early}, 8'h00);
        if (ok !== expOk) begin
            n_mismatch++;
            $display("Error readDone expected %b seen %b", expOk, ok);
            finish_test();
        end else begin
            check("dataOe", {7'h00, oe}, {7'h00, expOk});
            if (expOk) begin
                check("dataOut", d, e);
            end
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        int i;
        rst            = 1'b1;
        powerFail      = 1'b1;
        backupActive   = 1'b0;
        batteryHealthy = 1'b1;
        n_mismatch     = 0;
        n_compared     = 0;
        repeat (4) @(posedge clk);
        check("backupEnabled", {7'h00, backupEnabled === 1'b1}, 8'h00);
        rst       <= 1'b0;
        powerFail <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("backupEnabled", {7'h00, backupEnabled}, 8'h01);
        check("dataOeIdle", {7'h00, dataOe}, 8'h00);
        for (i = 0; i < 8; i++) begin
            rd(OFFS_CONTROL + 11'(i), resetVal[i], 1'b1, 1'b1);
        end
        for (i = 0; i < 3; i++) begin
            wr(ramAddr[i], ramData[i], i == 1);
        end
        for (i = 0; i < 3; i++) begin
            rd(ramAddr[i], ramData[i], i == 2, 1'b1);
        end
        for (i = 0; i < 8; i++) begin
            wr(OFFS_CONTROL + 11'(i), setVal[i], 1'b0);
        end
        wr(OFFS_CONTROL, 8'h39, 1'b0);
        for (i = 0; i < 8; i++) begin
            rd(OFFS_CONTROL + 11'(i), readVal[i], 1'b1, 1'b1);
        end
        @(posedge clk);
        batteryHealthy <= 1'b0;
        rd(OFFS_WEEKDAY, 8'h3f, 1'b1, 1'b1);
        @(posedge clk);
        batteryHealthy <= 1'b1;
        wr(OFFS_CONTROL, 8'h79, 1'b0);
        rd(OFFS_CONTROL, 8'h79, 1'b1, 1'b1);
        rd(OFFS_SECONDS, 8'hd9, 1'b1, 1'b1);
        wr(OFFS_CONTROL, 8'h39, 1'b0);
        @(posedge clk);
        powerFail    <= 1'b1;
        backupActive <= 1'b1;
        wr(ramAddr[1], 8'h00, 1'b0);
        rd(ramAddr[1], 8'h00, 1'b1, 1'b0);
        rd(OFFS_YEAR, 8'h00, 1'b1, 1'b0);
        @(posedge clk);
        powerFail    <= 1'b0;
        backupActive <= 1'b0;
        rd(ramAddr[1], ramData[1], 1'b1, 1'b1);
        rd(OFFS_YEAR, 8'h99, 1'b1, 1'b1);
        wr(OFFS_CONTROL, 8'h80, 1'b0);
        wr(OFFS_SECONDS, 8'h59, 1'b0);
        wr(OFFS_WEEKDAY, 8'h7f, 1'b0);
        wr(OFFS_CONTROL, 8'h39, 1'b0);
        // Square wave starts low at a freshly loaded second
        rd(OFFS_SECONDS, 8'h58, 1'b1, 1'b1);
        wr(OFFS_WEEKDAY, 8'h3f, 1'b0);
        rd(OFFS_SECONDS, 8'h59, 1'b1, 1'b1);
        #1;
        check("backupEnabled", {7'h00, backupEnabled}, 8'h01);
        finish_test();
    end
endmodule
`default_nettype wire
